// ==== lpd_led_pwm_driver.sv ====
// four channel led pwm driver: apb registers, serial bus address logic, pwm
//
// Summary of operation
// R1: each output has an 8-bit pwm near 97 kHz, duty 0 to 99.6 %
// R2: group pwm dims all outputs at about 190 Hz by one value
// R3: blink mode group period programmable from 24 Hz to 10.73 s; the code reaches 10.67 s at most
// R4: each output selects off, on, individual pwm, or both pwms
// R5: outputs open-drain or totem-pole by software, totem-pole after reset
// R6: new output settings apply per write or at stop, stop by default
// R7: output-enable pin high forces all outputs to 1, 0 or high-z
// R8: output-enable pin acts on outputs without clock or bus delay
// R9: the controller may pulse output-enable as an external pwm
// R10: software reset call returns all registers to reset defaults, leds off
// R11: individual brightness resets to off and scales linearly
// R12: group brightness resets to maximum so it has no effect; the code still blanks both-pwm outputs 1 step in 256
// R13: device answers one all-call and three sub-call addresses, each switchable
// R14: seven address pins set the own address; variants act alike
// R15: all timing derives from a 25 MHz internal rate; blink steps and glitch filter count the 100 MHz clock instead
// R16: data and clock pins pass a glitch filter before protocol logic
// R17: link runs at clock rates up to 1 MHz
// R18: all-call enabled after reset at E0h, acked for write and read
// R19: sub-calls disabled after reset at E2h, E4h, E8h, not acked
// R20: reset call acked only with write direction
// R21: both-pwm mode is the logical and of the two pwms
// R22: brightness zero never active, each count adds 1/256 period
//
// Chosen here: the register addresses and the APB register port.
`include "lpd_consts.svh"
`default_nettype none
module lpd_led_pwm_driver
  import lpd_pkg::*;
#(
  parameter int BLINK_STEP_CYC = `LPD_BLINK_STEP_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  input  wire logic [6:0]  addrPin,
  input  wire logic        outEnableN,
  output logic [3:0]       ledOut,
  output logic [3:0]       ledOutOe
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0]  mode_reg;
  logic [7:0]  addrEn_reg;
  logic [6:0]  callAddr_reg [4];
  logic [7:0]  stgPend_reg [`LPD_STG_N];
  logic [7:0]  stgLive_reg [`LPD_STG_N];
  logic        commitPending_reg;
  logic        swResetPulse_reg;
  logic        commitStop_reg;
  logic        regReset;
  logic        apbAccess;
  logic        wrEn;
  logic [3:0]  stgHit;
  logic [2:0]  callHit;
  logic        mapped;
  logic [31:0] readValue;
  logic        ackMode;
  logic [3:0]  ledActive_reg;
  lpd_link_t   linkState_reg;

  function automatic logic [3:0] stgDecode(input logic [7:0] a);
    case (a)
      `LPD_OFF_BRIGHT0:  stgDecode = 4'h8;
      `LPD_OFF_BRIGHT1:  stgDecode = 4'h9;
      `LPD_OFF_BRIGHT2:  stgDecode = 4'ha;
      `LPD_OFF_BRIGHT3:  stgDecode = 4'hb;
      `LPD_OFF_GRP_DUTY: stgDecode = 4'hc;
      `LPD_OFF_GRP_FREQ: stgDecode = 4'hd;
      `LPD_OFF_LED_SEL:  stgDecode = 4'he;
      default:           stgDecode = 4'h0;
    endcase
  endfunction : stgDecode

  function automatic logic [2:0] callDecode(input logic [7:0] a);
    case (a)
      `LPD_OFF_ALL_CALL: callDecode = 3'h4;
      `LPD_OFF_SUB1:     callDecode = 3'h5;
      `LPD_OFF_SUB2:     callDecode = 3'h6;
      `LPD_OFF_SUB3:     callDecode = 3'h7;
      default:           callDecode = 3'h0;
    endcase
  endfunction : callDecode

  ////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  assign regReset  = reset | swResetPulse_reg; // R10
  assign apbAccess = psel & penable;
  assign wrEn      = apbAccess & pwrite;
  assign stgHit    = stgDecode(paddr);
  assign callHit   = callDecode(paddr);
  assign ackMode   = mode_reg[`LPD_MODE_ACK_BIT];
  assign mapped    = stgHit[3] | callHit[2] | (paddr == `LPD_OFF_MODE)
                   | (paddr == `LPD_OFF_ADDR_EN) | (paddr == `LPD_OFF_STATUS);
  assign pready    = 1'b1;
  assign pslverr   = apbAccess & ~mapped;

  always_comb begin
    readValue = 32'h0;
    if (stgHit[3])
      readValue[7:0] = stgPend_reg[stgHit[2:0]];
    else if (callHit[2])
      readValue[6:0] = callAddr_reg[callHit[1:0]];
    else if (paddr == `LPD_OFF_MODE)
      readValue[7:0] = mode_reg;
    else if (paddr == `LPD_OFF_ADDR_EN)
      readValue[7:0] = addrEn_reg;
    else if (paddr == `LPD_OFF_STATUS)
      readValue[5:0] = {commitPending_reg, linkState_reg != LINK_IDLE, ledActive_reg};
  end

  always_ff @(posedge clk) begin
    if (reset)
      prdata <= 32'h0;
    else if (psel & ~penable & ~pwrite)
      prdata <= readValue;
  end

  always_ff @(posedge clk) begin
    if (regReset) begin
      mode_reg        <= `LPD_MODE_RST; // R5 R6 R7
      addrEn_reg      <= `LPD_ADDR_EN_RST; // R18 R19
      callAddr_reg[0] <= `LPD_ALL_CALL_RST; // R18
      callAddr_reg[1] <= `LPD_SUB1_RST; // R19
      callAddr_reg[2] <= `LPD_SUB2_RST;
      callAddr_reg[3] <= `LPD_SUB3_RST;
    end else if (wrEn) begin
      if (paddr == `LPD_OFF_MODE)
        mode_reg <= pwdata[7:0];
      if (paddr == `LPD_OFF_ADDR_EN)
        addrEn_reg <= {4'h0, pwdata[3:0]}; // R13
      if (callHit[2])
        callAddr_reg[callHit[1:0]] <= pwdata[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // staged output settings: pending copy, live copy used by the pwm
  genvar gi;
  generate
    for (gi = 0; gi < `LPD_STG_N; gi++) begin : g_stg
      localparam logic [7:0] RST_VAL = (gi == 4) ? `LPD_GRP_DUTY_RST : `LPD_STG_RST; // R11 R12
      always_ff @(posedge clk) begin
        if (regReset)
          stgPend_reg[gi] <= RST_VAL;
        else if (wrEn && stgHit[3] && stgHit[2:0] == 3'(gi))
          stgPend_reg[gi] <= pwdata[7:0];
      end
      always_ff @(posedge clk) begin
        if (regReset)
          stgLive_reg[gi] <= RST_VAL;
        else if (ackMode && wrEn && stgHit[3] && stgHit[2:0] == 3'(gi))
          stgLive_reg[gi] <= pwdata[7:0]; // R6
        else if (!ackMode && commitStop_reg)
          stgLive_reg[gi] <= stgPend_reg[gi]; // R6
      end
    end
  endgenerate

  // a write in the commit cycle keeps the pending flag set
  always_ff @(posedge clk) begin
    if (regReset)
      commitPending_reg <= 1'b0;
    else if (!ackMode && wrEn && stgHit[3])
      commitPending_reg <= 1'b1;
    else if (commitStop_reg || ackMode)
      commitPending_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // timebase: 25 MHz tick, individual and group pwm counters
  logic [1:0]  oscCnt_reg;
  logic        oscTick;
  logic [7:0]  pwmCnt_reg;
  logic [3:0]  dimCnt_reg;
  logic [23:0] baseCnt_reg;
  logic [7:0]  freqCnt_reg;
  logic [7:0]  grpCnt_reg;
  logic        pwmWrap;
  logic        dimStep;
  logic        blinkStep;
  logic        grpActive;

  assign oscTick   = oscCnt_reg == 2'(`LPD_OSC_DIV - 1); // R15
  assign pwmWrap   = oscTick && pwmCnt_reg == 8'hff;
  assign dimStep   = pwmWrap && dimCnt_reg == 4'(`LPD_GRP_DIM_DIV - 1); // R2
  assign blinkStep = baseCnt_reg == 24'(BLINK_STEP_CYC - 1)
                     && freqCnt_reg == stgLive_reg[`LPD_STG_GRP_FREQ]; // R3
  assign grpActive = grpCnt_reg < stgLive_reg[`LPD_STG_GRP_DUTY]; // R2 R22

  always_ff @(posedge clk) begin
    if (reset)
      oscCnt_reg <= 2'h0;
    else
      oscCnt_reg <= oscTick ? 2'h0 : oscCnt_reg + 2'h1;
  end

  always_ff @(posedge clk) begin
    if (reset)
      pwmCnt_reg <= 8'h0;
    else if (oscTick)
      pwmCnt_reg <= pwmCnt_reg + 8'h1; // R1
  end

  always_ff @(posedge clk) begin
    if (reset)
      dimCnt_reg <= 4'h0;
    else if (dimStep)
      dimCnt_reg <= 4'h0;
    else if (pwmWrap)
      dimCnt_reg <= dimCnt_reg + 4'h1;
  end

  // blink period is (freq + 1) base steps per group count
  always_ff @(posedge clk) begin
    if (reset || baseCnt_reg == 24'(BLINK_STEP_CYC - 1))
      baseCnt_reg <= 24'h0;
    else
      baseCnt_reg <= baseCnt_reg + 24'h1;
  end

  always_ff @(posedge clk) begin
    if (reset || blinkStep)
      freqCnt_reg <= 8'h0;
    else if (baseCnt_reg == 24'(BLINK_STEP_CYC - 1))
      freqCnt_reg <= freqCnt_reg + 8'h1; // R3
  end

  always_ff @(posedge clk) begin
    if (reset)
      grpCnt_reg <= 8'h0;
    else if (mode_reg[`LPD_MODE_BLINK_BIT] ? blinkStep : dimStep)
      grpCnt_reg <= grpCnt_reg + 8'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // per output select, stage and forced state
  logic [3:0] drvLevel_reg;
  logic [3:0] drvOe_reg;
  lpd_oes_t   oesSel;

  assign oesSel = lpd_oes_t'(mode_reg[`LPD_MODE_OES_LSB +: 2]);

  generate
    for (gi = 0; gi < 4; gi++) begin : g_led
      lpd_sel_t sel;
      logic     indActive;
      assign sel       = lpd_sel_t'(stgLive_reg[`LPD_STG_LED_SEL][2*gi +: 2]);
      assign indActive = pwmCnt_reg < stgLive_reg[gi]; // R1 R11 R22
      always_ff @(posedge clk) begin
        if (regReset)
          ledActive_reg[gi] <= 1'b0;
        else
          case (sel) // R4
            LPD_SEL_OFF: ledActive_reg[gi] <= 1'b0;
            LPD_SEL_ON:  ledActive_reg[gi] <= 1'b1;
            LPD_SEL_IND: ledActive_reg[gi] <= indActive;
            LPD_SEL_GRP: ledActive_reg[gi] <= indActive & grpActive; // R21
            default:     ledActive_reg[gi] <= 1'b0;
          endcase
      end
      // active drives low; open-drain releases instead of driving high
      always_ff @(posedge clk) begin
        if (regReset) begin
          drvLevel_reg[gi] <= 1'b1; // R10
          drvOe_reg[gi]    <= 1'b1;
        end else if (mode_reg[`LPD_MODE_OD_BIT]) begin
          drvLevel_reg[gi] <= 1'b0; // R5
          drvOe_reg[gi]    <= ledActive_reg[gi];
        end else begin
          drvLevel_reg[gi] <= ~ledActive_reg[gi]; // R5
          drvOe_reg[gi]    <= 1'b1;
        end
      end
    end
  endgenerate

  // pin acts straight on the pads, no sampling
  always_comb begin
    ledOut   = drvLevel_reg;
    ledOutOe = drvOe_reg;
    if (outEnableN) begin // R7 R8
      case (oesSel)
        LPD_OES_ZERO: begin
          ledOut   = 4'h0;
          ledOutOe = 4'hf;
        end
        LPD_OES_ONE: begin
          ledOut   = 4'hf;
          ledOutOe = {4{~mode_reg[`LPD_MODE_OD_BIT]}};
        end
        default: begin
          ledOut   = 4'h0;
          ledOutOe = 4'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial link: filtered pins, address match, reset call
  logic       sclF;
  logic       sdaF;
  logic       sclPrev_reg;
  logic       sdaPrev_reg;
  logic [6:0] addrSyncA_reg;
  logic [6:0] addrSyncB_reg;
  logic [7:0] shift_reg;
  logic [3:0] bitCnt_reg;
  logic       gcall_reg;
  logic       keyOk_reg;
  logic       sdaDrive_reg;
  logic       sclRise;
  logic       sclFall;
  logic       startCond;
  logic       stopCond;
  logic       addrAck;

  lpd_glitch_filter u_sclFilt (.clk(clk), .reset(reset), .pinIn(scl), .filtOut(sclF)); // R16
  lpd_glitch_filter u_sdaFilt (.clk(clk), .reset(reset), .pinIn(sdaIn), .filtOut(sdaF)); // R16

  always_ff @(posedge clk) begin
    if (reset) begin
      sclPrev_reg   <= 1'b1;
      sdaPrev_reg   <= 1'b1;
      addrSyncA_reg <= 7'h0;
      addrSyncB_reg <= 7'h0;
    end else begin
      sclPrev_reg   <= sclF;
      sdaPrev_reg   <= sdaF;
      addrSyncA_reg <= addrPin; // R14
      addrSyncB_reg <= addrSyncA_reg;
    end
  end

  // edges found at 10 ns resolution, ample for a 1 MHz link
  assign sclRise   = sclF & ~sclPrev_reg; // R17
  assign sclFall   = ~sclF & sclPrev_reg;
  assign startCond = sclF & sclPrev_reg & sdaPrev_reg & ~sdaF;
  assign stopCond  = sclF & sclPrev_reg & ~sdaPrev_reg & sdaF;

  always_comb begin
    addrAck = shift_reg[7:1] == addrSyncB_reg; // R14
    for (int i = 0; i < 4; i++)
      if (addrEn_reg[i] && shift_reg[7:1] == callAddr_reg[i])
        addrAck = 1'b1; // R13 R18 R19
    if (shift_reg == `LPD_SOFTWARE_RESET_CALL_BYTE)
      addrAck = 1'b1; // R20
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      linkState_reg    <= LINK_IDLE;
      shift_reg        <= 8'h0;
      bitCnt_reg       <= 4'h0;
      gcall_reg        <= 1'b0;
      keyOk_reg        <= 1'b0;
      sdaDrive_reg     <= 1'b0;
      swResetPulse_reg <= 1'b0;
      commitStop_reg   <= 1'b0;
    end else begin
      swResetPulse_reg <= 1'b0;
      commitStop_reg   <= 1'b0;
      if (startCond) begin
        linkState_reg <= LINK_ADDR;
        bitCnt_reg    <= 4'h0;
        sdaDrive_reg  <= 1'b0;
      end else if (stopCond) begin
        linkState_reg  <= LINK_IDLE;
        sdaDrive_reg   <= 1'b0;
        commitStop_reg <= 1'b1; // R6
      end else begin
        case (linkState_reg)
          LINK_ADDR, LINK_DATA: begin
            if (sclRise) begin
              shift_reg  <= {shift_reg[6:0], sdaF};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (sclFall && bitCnt_reg == 4'h8) begin
              if (linkState_reg == LINK_ADDR) begin
                linkState_reg <= addrAck ? LINK_ACK_ADDR : LINK_SKIP;
                sdaDrive_reg  <= addrAck;
                gcall_reg     <= shift_reg == `LPD_SOFTWARE_RESET_CALL_BYTE; // R20
                keyOk_reg     <= 1'b0;
              end else begin
                linkState_reg <= LINK_ACK_DATA;
                sdaDrive_reg  <= 1'b1;
                if (gcall_reg && !keyOk_reg && shift_reg == `LPD_SOFTWARE_RESET_CALL_KEY1)
                  keyOk_reg <= 1'b1;
                else if (gcall_reg && keyOk_reg && shift_reg == `LPD_SOFTWARE_RESET_CALL_KEY2) begin
                  swResetPulse_reg <= 1'b1; // R10
                  gcall_reg        <= 1'b0;
                end else
                  gcall_reg <= 1'b0;
              end
            end
          end
          LINK_ACK_ADDR, LINK_ACK_DATA: begin
            if (sclFall) begin
              sdaDrive_reg <= 1'b0;
              bitCnt_reg   <= 4'h0;
              // read transfers are acked but return released data
              linkState_reg <= (linkState_reg == LINK_ACK_ADDR && shift_reg[0])
                               ? LINK_SKIP : LINK_DATA; // R18
            end
          end
          LINK_IDLE, LINK_SKIP: linkState_reg <= linkState_reg;
          default:              linkState_reg <= LINK_IDLE;
        endcase
      end
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe  = sdaDrive_reg;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_tickGap;
    !oscTick [*3] ##1 oscTick;
  endsequence

  AST_OSC_CADENCE: assert property (oscTick |=> s_tickGap) // R15
    else $error("internal tick cadence broken");
  AST_SEL_OFF: assert property ( // R4
    stgLive_reg[`LPD_STG_LED_SEL][1:0] == 2'h0 |=> !ledActive_reg[0])
    else $error("output 0 active while off");
  AST_SEL_ON: assert property ( // R4
    stgLive_reg[`LPD_STG_LED_SEL][1:0] == 2'h1 |=> ##1 ledOutOe[0] || outEnableN)
    else $error("output 0 not driven while on");
  AST_ZERO_DUTY: assert property ( // R22
    stgLive_reg[0] == 8'h0 && stgLive_reg[`LPD_STG_LED_SEL][1] |=> !ledActive_reg[0])
    else $error("zero brightness produced active time");
  AST_OE_HIZ: assert property ( // R7
    outEnableN && mode_reg[3:2] == 2'h2 |-> ledOutOe == 4'h0)
    else $error("outputs driven while forced to high impedance");
  AST_RESET_DEF: assert property ( // R11
    $fell(reset) |-> stgLive_reg[0] == 8'h0 && stgLive_reg[4] == `LPD_GRP_DUTY_RST)
    else $error("brightness defaults wrong after reset");
  AST_SOFTWARE_RESET_CALL: assert property ( // R10
    swResetPulse_reg |=> mode_reg == `LPD_MODE_RST && (ledOut == 4'hf || outEnableN)
    && drvLevel_reg == 4'hf)
    else $error("reset call did not restore defaults");
  AST_ACK_UPDATE: assert property ( // R6
    ackMode && wrEn && paddr == `LPD_OFF_BRIGHT0 && !swResetPulse_reg
    |=> stgLive_reg[0] == $past(pwdata[7:0]))
    else $error("per-write update not applied");
  AST_STOP_HOLD: assert property ( // R6
    !ackMode && wrEn && paddr == `LPD_OFF_BRIGHT0 && !commitStop_reg && !swResetPulse_reg
    |=> stgLive_reg[0] == $past(stgLive_reg[0]))
    else $error("live setting changed before stop");
endmodule : lpd_led_pwm_driver
`default_nettype wire

// ==== lpd_consts.svh ====
// register offsets, reset values and timing counts of the led pwm driver
`ifndef LPD_CONSTS_SVH
`define LPD_CONSTS_SVH

`define LPD_OFF_MODE      8'h00
`define LPD_OFF_BRIGHT0   8'h04
`define LPD_OFF_BRIGHT1   8'h08
`define LPD_OFF_BRIGHT2   8'h0c
`define LPD_OFF_BRIGHT3   8'h10
`define LPD_OFF_GRP_DUTY  8'h14
`define LPD_OFF_GRP_FREQ  8'h18
`define LPD_OFF_LED_SEL   8'h1c
`define LPD_OFF_ADDR_EN   8'h20
`define LPD_OFF_ALL_CALL  8'h24
`define LPD_OFF_SUB1      8'h28
`define LPD_OFF_SUB2      8'h2c
`define LPD_OFF_SUB3      8'h30
`define LPD_OFF_STATUS    8'h34

`define LPD_MODE_ACK_BIT  0
`define LPD_MODE_OD_BIT   1
`define LPD_MODE_OES_LSB  2
`define LPD_MODE_BLINK_BIT 4
`define LPD_MODE_RST      8'h08
`define LPD_ADDR_EN_RST   8'h01
`define LPD_ALL_CALL_RST  7'h70
`define LPD_SUB1_RST      7'h71
`define LPD_SUB2_RST      7'h72
`define LPD_SUB3_RST      7'h74
`define LPD_GRP_DUTY_RST  8'hff
`define LPD_STG_RST       8'h00

`define LPD_STG_N         7
`define LPD_STG_GRP_DUTY  3'd4
`define LPD_STG_GRP_FREQ  3'd5
`define LPD_STG_LED_SEL   3'd6

`define LPD_SOFTWARE_RESET_CALL_BYTE    8'h00
`define LPD_SOFTWARE_RESET_CALL_KEY1    8'ha5
`define LPD_SOFTWARE_RESET_CALL_KEY2    8'h5a

`define LPD_CLK_HZ        100000000
`define LPD_OSC_HZ        25000000
`define LPD_OSC_DIV       (`LPD_CLK_HZ / `LPD_OSC_HZ)
`define LPD_GRP_DIM_HZ    190
`define LPD_GRP_DIM_DIV   (`LPD_OSC_HZ / (`LPD_GRP_DIM_HZ * 65536))
`define LPD_BLINK_MAX_HZ  24
`define LPD_BLINK_STEP_CYC (`LPD_CLK_HZ / (`LPD_BLINK_MAX_HZ * 256))
`define LPD_SPIKE_NS      50
`define LPD_FILT_CYC      ((`LPD_SPIKE_NS * (`LPD_CLK_HZ / 1000000) + 999) / 1000)

`endif

// ==== lpd_pkg.sv ====
// types of the led pwm driver
`default_nettype none
package lpd_pkg;
  typedef enum logic [1:0] {LPD_SEL_OFF, LPD_SEL_ON, LPD_SEL_IND, LPD_SEL_GRP} lpd_sel_t;
  typedef enum logic [1:0] {LPD_OES_ZERO, LPD_OES_ONE, LPD_OES_HIZ} lpd_oes_t;
  typedef enum logic [2:0] {
    LINK_IDLE, LINK_ADDR, LINK_ACK_ADDR, LINK_DATA, LINK_ACK_DATA, LINK_SKIP
  } lpd_link_t;
endpackage : lpd_pkg
`default_nettype wire

// ==== lpd_glitch_filter.sv ====
// two-flop synchroniser followed by a spike filter for one bus pin
`include "lpd_consts.svh"
`default_nettype none
module lpd_glitch_filter (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic pinIn,
  output logic      filtOut
);
  logic       syncA_reg;
  logic       syncB_reg;
  logic [2:0] stableCnt_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      syncA_reg <= 1'b1;
      syncB_reg <= 1'b1;
    end else begin
      syncA_reg <= pinIn;
      syncB_reg <= syncA_reg;
    end
  end

  // output follows only after the level held for the spike time
  always_ff @(posedge clk) begin
    if (reset) begin
      filtOut       <= 1'b1;
      stableCnt_reg <= 3'h0;
    end else if (syncB_reg == filtOut) begin
      stableCnt_reg <= 3'h0;
    end else if (stableCnt_reg == 3'(`LPD_FILT_CYC - 1)) begin
      filtOut       <= syncB_reg;
      stableCnt_reg <= 3'h0;
    end else begin
      stableCnt_reg <= stableCnt_reg + 3'h1;
    end
  end
endmodule : lpd_glitch_filter
`default_nettype wire

// ==== lpd_link_master.sv ====
// serial link master model driving the led driver bus pins
`default_nettype none
module lpd_link_master (
  input  wire logic clk,
  input  wire logic sdaOut,
  input  wire logic sdaOe,
  output logic      scl,
  output wire logic sdaIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic masterLow = 1'b0;
  // wired-and with pull-up
  assign sdaIn = (masterLow | (sdaOe & ~sdaOut)) ? 1'b0 : 1'b1;
  initial scl = 1'b1;
  // quarter bit of a 160 ns link clock
  task automatic q(input int n);
    repeat (4 * n) @(posedge clk);
  endtask : q
  task automatic start();
    masterLow <= 1'b1;
    q(2);
    scl <= 1'b0;
    q(1);
  endtask : start
  task automatic stop();
    masterLow <= 1'b1;
    q(1);
    scl <= 1'b1;
    q(1);
    masterLow <= 1'b0;
    q(2);
  endtask : stop
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic [8:0] s;
    s = {b, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      masterLow <= ~s[i];
      q(1);
      scl <= 1'b1;
      q(2);
      ack = (sdaIn === 1'b0);
      scl <= 1'b0;
      q(1);
    end
  endtask : sendByte
endmodule : lpd_link_master
`default_nettype wire

// ==== lpd_led_pwm_driver_tb.sv ====
// self-checking bench of the four channel led pwm driver
`include "lpd_consts.svh"
`default_nettype none
module lpd_led_pwm_driver_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        outEnableN = 1'b0;
  logic [6:0]  addrPin = 7'h15;
  logic [31:0] prdata;
  logic        pready, pslverr, sdaOut, sdaOe, scl;
  wire logic   sdaIn;
  logic [3:0]  ledOut, ledOutOe;
  int          badCount = 0;
  int          checksDone = 0;
  always #5 clk = ~clk;
  lpd_led_pwm_driver #(.BLINK_STEP_CYC(4)) u_lpd_led_pwm_driver (.clk(clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl(scl), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrPin(addrPin), .outEnableN(outEnableN),
    .ledOut(ledOut), .ledOutOe(ledOutOe));
  lpd_link_master u_lpd_link_master (.clk(clk), .sdaOut(sdaOut), .sdaOe(sdaOe), .scl(scl),
    .sdaIn(sdaIn));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic completeRun();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : completeRun
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      badCount++;
      completeRun();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, {24'h0, d}, rd, err);
  endtask : wr
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk("register", exp, rd);
  endtask : rdChk
  task automatic countOn(input int i, input int exp);
    int c;
    c = 0;
    // select reaches the pad two clocks late
    repeat (4) @(posedge clk);
    repeat (1024) begin
      @(posedge clk);
      if (ledOut[i] === 1'b0) c++;
      else if (ledOut[i] !== 1'b1) c = c + 2048;
    end
    chk("active clocks", exp, c);
  endtask : countOn
  task automatic frame(input logic [7:0] b, input logic exp);
    logic ack;
    u_lpd_link_master.start();
    u_lpd_link_master.sendByte(b, ack);
    u_lpd_link_master.stop();
    chk("address ack", {31'h0, exp}, {31'h0, ack});
  endtask : frame
  ////////////////////////////////////////////////////////////////////////////////
  task automatic sRegReset();
    logic [7:0] a[7] = '{`LPD_OFF_MODE, `LPD_OFF_BRIGHT0, `LPD_OFF_BRIGHT3,
      `LPD_OFF_GRP_DUTY, `LPD_OFF_ADDR_EN, `LPD_OFF_ALL_CALL, `LPD_OFF_SUB3};
    logic [7:0] e[7] = '{8'h08, 8'h00, 8'h00, 8'hff, 8'h01, 8'h70, 8'h74};
    logic [31:0] rd;
    logic err;
    for (int i = 0; i < 7; i++) rdChk(a[i], {24'h0, e[i]});
    apb(1'b0, 8'hf0, 32'h0, rd, err);
    chk("unmapped error", 32'h1, {31'h0, err});
  endtask : sRegReset
  task automatic sOutEnable();
    chk("leds off", 32'hf, {28'h0, ledOut});
    chk("totem drive", 32'hf, {28'h0, ledOutOe});
    outEnableN <= 1'b1;
    #1 chk("forced high-z", 32'h0, {28'h0, ledOutOe});
    wr(`LPD_OFF_MODE, 8'h04);
    @(posedge clk);
    #1 chk("forced high", 32'hff, {24'h0, ledOutOe, ledOut});
    wr(`LPD_OFF_MODE, 8'h00);
    @(posedge clk);
    #1 chk("forced low", 32'h0, {28'h0, ledOut});
    @(posedge clk);
    outEnableN <= 1'b0;
    #1 chk("released", 32'hf, {28'h0, ledOut});
  endtask : sOutEnable
  task automatic sSelect();
    wr(`LPD_OFF_MODE, 8'h01);
    wr(`LPD_OFF_BRIGHT0, 8'h40);
    wr(`LPD_OFF_LED_SEL, 8'h02);
    countOn(0, 256);
    wr(`LPD_OFF_LED_SEL, 8'h01);
    countOn(0, 1024);
    wr(`LPD_OFF_BRIGHT0, 8'h00);
    wr(`LPD_OFF_LED_SEL, 8'h02);
    countOn(0, 0);
    wr(`LPD_OFF_MODE, 8'h11);
    wr(`LPD_OFF_GRP_DUTY, 8'h00);
    wr(`LPD_OFF_BRIGHT1, 8'hff);
    wr(`LPD_OFF_LED_SEL, 8'h0c);
    countOn(1, 0);
    wr(`LPD_OFF_MODE, 8'h03);
    wr(`LPD_OFF_LED_SEL, 8'h01);
    repeat (4) @(posedge clk);
    chk("open-drain enable", 32'h1, {28'h0, ledOutOe});
  endtask : sSelect
  task automatic sStop();
    wr(`LPD_OFF_MODE, 8'h01);
    wr(`LPD_OFF_LED_SEL, 8'h00);
    wr(`LPD_OFF_MODE, 8'h00);
    wr(`LPD_OFF_LED_SEL, 8'h01);
    wr(`LPD_OFF_BRIGHT0, 8'h80);
    repeat (6) @(posedge clk);
    chk("held until stop", 32'hf, {28'h0, ledOut});
    u_lpd_link_master.start();
    u_lpd_link_master.stop();
    repeat (6) @(posedge clk);
    chk("applied at stop", 32'he, {28'h0, ledOut});
  endtask : sStop
  task automatic sLink();
    logic [7:0] b[5] = '{8'he0, 8'he1, 8'he2, 8'h2a, 8'h01};
    logic e[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++) frame(b[i], e[i]);
    wr(`LPD_OFF_ADDR_EN, 8'h03);
    frame(8'he2, 1'b1);
    addrPin <= 7'h2b;
    frame(8'h56, 1'b1);
    frame(8'h2a, 1'b0);
  endtask : sLink
  task automatic sSwReset();
    logic ack;
    wr(`LPD_OFF_MODE, 8'h01);
    wr(`LPD_OFF_LED_SEL, 8'h01);
    u_lpd_link_master.start();
    u_lpd_link_master.sendByte(`LPD_SOFTWARE_RESET_CALL_BYTE, ack);
    chk("reset call ack", 32'h1, {31'h0, ack});
    u_lpd_link_master.sendByte(`LPD_SOFTWARE_RESET_CALL_KEY1, ack);
    u_lpd_link_master.sendByte(`LPD_SOFTWARE_RESET_CALL_KEY2, ack);
    u_lpd_link_master.stop();
    repeat (6) @(posedge clk);
    rdChk(`LPD_OFF_MODE, 32'h08);
    rdChk(`LPD_OFF_ADDR_EN, 32'h01);
    chk("leds off after call", 32'hf, {28'h0, ledOut});
  endtask : sSwReset
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    sRegReset();
    sOutEnable();
    sSelect();
    sStop();
    sLink();
    sSwReset();
    completeRun();
  end
endmodule : lpd_led_pwm_driver_tb
`default_nettype wire
